/* hw/ptw_controller.sv */
// controller end: sequences writes, file marks, edits and erases
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ptw_controller
	import ptw_pkg::*;
#(
	parameter int unsigned DIV = STROBE_DIV
) (
	input  wire logic   hclk,
	input  wire logic   hresetn,
	input  wire logic   ce,
	ptw_link_if.ctrl    link,
	input  wire logic   hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic   hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic   hready,
	output logic [31:0] hrdata,
	output logic        hreadyout,
	output logic        hresp
);
	typedef enum logic [10:0] {
		S_IDLE = 11'h001, S_WAITSTOP = 11'h002, S_REV = 11'h004, S_REVPOST = 11'h008,
		S_START = 11'h010, S_PRE = 11'h020, S_BURST = 11'h040, S_PREAMB = 11'h080,
		S_DATA = 11'h100, S_POSTAMB = 11'h200, S_POST = 11'h400
	} ptw_state_t;
	ptw_state_t  st;
	logic [2:0]  op;
	logic        seven, dual;
	logic [7:0]  ips;
	logic [15:0] len, left;
	logic [7:0]  dbuf;
	logic        dfull, done, rev_done;
	logic [31:0] tmr;
	logic [15:0] div_cnt;
	logic [7:0]  zeros;
	logic        phase, burst_bit;
	logic [1:0]  s_mot;
	logic        wr_ph;
	logic [7:0]  wr_addr;
	wire  tick    = (div_cnt == 16'h0);
	wire  tmr_end = (tmr == 32'h0);
	wire  stopped = ~s_mot[1];
	wire  is_edit = (op == PTW_OP_EDIT);
	wire  go_wr   = wr_ph & (wr_addr == OFS_CTRL) & hwdata[CTRL_GO] & (st == S_IDLE);
	wire  dat_wr  = wr_ph & (wr_addr == OFS_DATA);
	wire  ap      = hsel & hready & htrans[1];
	wire  [31:0] pre_ms = (op == PTW_OP_FMARK) ? PRE_FMARK_MS :
		dual ? (seven ? PRE_NORM_D7_MS : PRE_NORM_D9_MS) :
		(seven ? PRE_NORM_S7_MS : PRE_NORM_S9_MS);
	wire  [31:0] pre_cyc  = ptw_ms_cycles(pre_ms, ips);
	wire  [31:0] edit_cyc = ptw_ms_cycles(seven ? POST_EDIT7_MS : POST_EDIT9_MS, ips);
	wire  [31:0] post_cyc = ptw_ms_cycles(POST_WRITE_MS, ips);
	wire  [31:0] lead_cyc = ptw_ms_cycles(BOT_LEAD_MS, ips);
	wire  [31:0] brst_cyc = ptw_ms_cycles(BOT_BURST_MS, ips);
	wire  [31:0] tail_cyc = ptw_ms_cycles(BOT_TAIL_MS, ips);
	wire  [31:0] status   = {29'h0, done, ~dfull & (st == S_DATA), st != S_IDLE};
	wire  [8:0]  data_chr = {ptw_odd_parity(dbuf), dbuf};
	wire  strobe_ok = (op != PTW_OP_ERASE);
	// a file mark is zeros only, so it gets no all-ones closing character
	wire  [8:0]  zero_chr = 9'h000 & FMARK_MASK;
	wire  [8:0]  lead_end = (op == PTW_OP_FMARK) ? zero_chr : ALL_ONES;
	wire  last_zero = (zeros == 8'h0);
	wire  in_burst  = (tmr < brst_cyc + tail_cyc) & (tmr >= tail_cyc);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			wr_ph <= ap & hwrite;
			wr_addr <= haddr[7:0];
			if (ap & ~hwrite)
				hrdata <= (haddr[7:0] == OFS_STATUS) ? status :
					(haddr[7:0] == OFS_LENGTH) ? {16'h0, len} :
					(haddr[7:0] == OFS_CTRL) ? {16'h0, ips, 2'h0, dual, seven, op, 1'b0} : 32'h0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= S_IDLE;
			op <= 3'h0;
			seven <= 1'b0;
			dual <= 1'b0;
			ips <= 8'(RATED_IPS);
			len <= 16'h0;
			left <= 16'h0;
			dbuf <= 8'h00;
			dfull <= 1'b0;
			done <= 1'b0;
			rev_done <= 1'b0;
			tmr <= 32'h0;
			div_cnt <= 16'h0;
			zeros <= 8'h00;
			phase <= 1'b0;
			burst_bit <= 1'b0;
			s_mot <= 2'h0;
			link.write_select_request <= 1'b0;
			link.forward_run_cmd <= 1'b0;
			link.reverse_run_cmd <= 1'b0;
			link.overwrite_line <= 1'b0;
			link.write_amp_shutoff <= 1'b0;
			link.write_char_strobe <= 1'b0;
			link.write_parity_line <= 1'b0;
			link.write_char_lines <= 8'h00;
		end else if (ce) begin
			s_mot <= {s_mot[0], link.motion};
			div_cnt <= tick ? 16'(DIV / 2 - 1) : div_cnt - 16'h1;
			if (!tmr_end)
				tmr <= tmr - 32'h1;
			if (wr_ph & (wr_addr == OFS_LENGTH))
				len <= hwdata[15:0];
			if (dat_wr) begin
				dbuf <= hwdata[7:0];
				dfull <= 1'b1;
			end
			if (go_wr) begin
				op <= hwdata[CTRL_OP_LSB +: 3];
				seven <= hwdata[CTRL_SEVEN];
				dual <= hwdata[CTRL_DUAL];
				ips <= hwdata[CTRL_SPEED_LSB +: 8];
				done <= 1'b0;
				rev_done <= 1'b0;
				st <= S_WAITSTOP;
			end
			case (st)
				S_IDLE: begin
				end
				S_WAITSTOP: if (stopped) begin
					link.write_amp_shutoff <= 1'b0;
					if (is_edit & ~rev_done) begin
						link.write_select_request <= 1'b0;
						link.reverse_run_cmd <= 1'b1;
						tmr <= 32'hffff_ffff;
						st <= S_REV;
					end else begin
						link.write_select_request <= 1'b1;
						st <= S_START;
					end
				end
				S_REV: if (tmr_end | (tmr < 32'hffff_fff0)) begin
					tmr <= edit_cyc;
					st <= S_REVPOST;
				end
				S_REVPOST: if (tmr_end) begin
					link.reverse_run_cmd <= 1'b0;
					rev_done <= 1'b1;
					st <= S_WAITSTOP;
				end
				S_START: if (is_edit & ~link.overwrite_line) begin
					link.overwrite_line <= 1'b1;
				end else begin
					link.forward_run_cmd <= 1'b1;
					tmr <= (op == PTW_OP_BOT) ? lead_cyc + brst_cyc + tail_cyc : pre_cyc;
					st <= (op == PTW_OP_BOT) ? S_BURST : S_PRE;
				end
				S_BURST: begin
					if (tick) begin
						phase <= ~phase;
						link.write_char_strobe <= ~phase & in_burst;
						if (!phase) begin
							burst_bit <= ~burst_bit;
							link.write_parity_line <= ~burst_bit & in_burst;
							link.write_char_lines <= 8'h00;
						end
					end
					// the tail of the load point delay runs on in S_PRE
					if (tmr < tail_cyc) begin
						link.write_char_strobe <= 1'b0;
						link.write_parity_line <= 1'b0;
						phase <= 1'b0;
						op <= 3'(PTW_OP_WRITE);
						st <= S_PRE;
					end
				end
				S_PRE: if (tmr_end) begin
					zeros <= 8'((op == PTW_OP_FMARK) ? FMARK_ZEROS : PREAMBLE_ZEROS);
					left <= len;
					st <= S_PREAMB;
				end
				S_PREAMB: if (tick) begin
					phase <= ~phase;
					link.write_char_strobe <= ~phase & strobe_ok;
					if (!phase) begin
						{link.write_parity_line, link.write_char_lines} <=
							(zeros == 8'h0) ? lead_end : zero_chr;
						zeros <= zeros - 8'h1;
						if (zeros == 8'h0) begin
							st <= (op == PTW_OP_FMARK) ? S_POST : S_DATA;
							tmr <= post_cyc;
						end
					end
				end
				S_DATA: if (tick) begin
					phase <= ~phase;
					link.write_char_strobe <= ~phase & strobe_ok & (dfull | (op == PTW_OP_ERASE));
					if (!phase & (dfull | (op == PTW_OP_ERASE))) begin
						{link.write_parity_line, link.write_char_lines} <= data_chr;
						dfull <= 1'b0;
						left <= left - 16'h1;
						if (left == 16'h1) begin
							zeros <= 8'(POSTAMBLE_ZEROS) + 8'h1;
							st <= S_POSTAMB;
						end
					end
				end
				S_POSTAMB: if (tick) begin
					phase <= ~phase;
					link.write_char_strobe <= ~phase & strobe_ok;
					if (!phase) begin
						{link.write_parity_line, link.write_char_lines} <=
							(zeros == 8'(POSTAMBLE_ZEROS) + 8'h1) ? ALL_ONES : 9'h000;
						zeros <= zeros - 8'h1;
					end else if (last_zero) begin
						link.write_amp_shutoff <= link.overwrite_line;
						tmr <= post_cyc;
						st <= S_POST;
					end
				end
				S_POST: begin
					link.write_char_strobe <= 1'b0;
					if (tmr_end) begin
						link.forward_run_cmd <= 1'b0;
						link.overwrite_line <= 1'b0;
						done <= 1'b1;
						st <= S_IDLE;
					end
				end
				default: st <= S_IDLE;
			endcase
		end
	end
endmodule

/* hw/ptw_pkg.sv */
// package of constants and types shared by the tape write sequencer ends
// Functional notes
// - controller drops write-select before edit reverse pass
// - reverse-run starts reverse motion in read mode
// - edit reverse post-delay 8 or 13 ms
// - edit order: select, overwrite, then forward-run
// - forward-run with select and overwrite writes forward
// - normal pre-delay 23/28 single, 17/22 dual ms
// - strobe at 2x1600x speed within 0.25 percent
// - preamble, data, postamble, one strobe per character
// - overwrite record same length as original
// - shutoff asserted after last postamble zero byte
// - overwrite plus shutoff kills write and erase current
// - 3 ms post-delay then drop forward-run
// - transport stops within 15 ms of run removal
// - write-enable flop sets after forward-run with select
// - file mark: select, forward-run, 150 ms pre-delay
// - file mark zeros, tracks 1,3,4 held false
// - 3 ms post-delay after file mark, drop run
// - write-enable flop holds until read, rewind, offline, interlock
// - data characters carry odd parity
// - erase gap by strobe-suppressed dummy write
// - scale delays by 25 over actual speed
// - load point: 15 ms, 100 ms burst, 135 ms
// - burst on parity track only, data lines false
package ptw_pkg;
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned MS_PER_SEC      = 1000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_SEC;
	localparam int unsigned BASE_IPS        = 25;
	localparam int unsigned RATED_IPS       = 25;
	localparam int unsigned BPI             = 1600;
	localparam int unsigned STROBE_HZ       = 2 * BPI * RATED_IPS;
	localparam int unsigned STROBE_DIV      = CLK_HZ / STROBE_HZ;
	localparam int unsigned LINK_DIV        = 4;
	localparam int unsigned PRE_NORM_S9_MS  = 23;
	localparam int unsigned PRE_NORM_S7_MS  = 28;
	localparam int unsigned PRE_NORM_D9_MS  = 17;
	localparam int unsigned PRE_NORM_D7_MS  = 22;
	localparam int unsigned PRE_FMARK_MS    = 150;
	localparam int unsigned POST_WRITE_MS   = 3;
	localparam int unsigned POST_EDIT9_MS   = 8;
	localparam int unsigned POST_EDIT7_MS   = 13;
	localparam int unsigned BOT_LEAD_MS     = 15;
	localparam int unsigned BOT_BURST_MS    = 100;
	localparam int unsigned BOT_TAIL_MS     = 135;
	localparam int unsigned STOP_TIME_MS    = 15;
	localparam int unsigned PREAMBLE_ZEROS  = 40;
	localparam int unsigned POSTAMBLE_ZEROS = 40;
	localparam int unsigned FMARK_ZEROS     = 40;
	localparam logic [8:0]  FMARK_MASK      = 9'h1e5;
	localparam logic [8:0]  ALL_ONES        = 9'h1ff;
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_DATA        = 8'h08;
	localparam logic [7:0]  OFS_LENGTH      = 8'h0c;
	localparam int unsigned CTRL_GO         = 0;
	localparam int unsigned CTRL_OP_LSB     = 1;
	localparam int unsigned CTRL_SEVEN      = 4;
	localparam int unsigned CTRL_DUAL       = 5;
	localparam int unsigned CTRL_SPEED_LSB  = 8;
	localparam int unsigned STAT_BUSY       = 0;
	localparam int unsigned STAT_DREQ       = 1;
	localparam int unsigned STAT_DONE       = 2;
	typedef enum logic [2:0] {
		PTW_OP_WRITE = 3'h0,
		PTW_OP_BOT   = 3'h1,
		PTW_OP_FMARK = 3'h2,
		PTW_OP_EDIT  = 3'h3,
		PTW_OP_ERASE = 3'h4
	} ptw_op_t;
	function automatic logic [31:0] ptw_ms_cycles(input int unsigned ms, input logic [7:0] ips);
		logic [31:0] num;
		num = 32'(ms * BASE_IPS * CYC_PER_MS);
		return (ips == 8'h00) ? num : num / 32'(ips);
	endfunction
	function automatic logic ptw_odd_parity(input logic [7:0] d);
		return ~(^d);
	endfunction
endpackage

/* hw/ptw_link_if.sv */
// interface carrying the controller to transport write link
`timescale 1ns/1ps
interface ptw_link_if;
	logic       write_select_request;
	logic       forward_run_cmd;
	logic       reverse_run_cmd;
	logic       overwrite_line;
	logic       write_amp_shutoff;
	logic       write_char_strobe;
	logic       write_parity_line;
	logic [7:0] write_char_lines;
	logic       motion;
	modport ctrl (
		output write_select_request, forward_run_cmd, reverse_run_cmd, overwrite_line,
		output write_amp_shutoff, write_char_strobe, write_parity_line, write_char_lines,
		input  motion
	);
	modport xport (
		input  write_select_request, forward_run_cmd, reverse_run_cmd, overwrite_line,
		input  write_amp_shutoff, write_char_strobe, write_parity_line, write_char_lines,
		output motion
	);
endinterface

/* hw/ptw_transport.sv */
// transport end: motion, write mode and write-enable flop
`timescale 1ns/1ps
module ptw_transport
	import ptw_pkg::*;
#(
	parameter int unsigned STOP_MS = STOP_TIME_MS
) (
	input  wire logic   hclk,
	input  wire logic   hresetn,
	input  wire logic   ce,
	ptw_link_if.xport   link,
	input  wire logic   read_cmd,
	input  wire logic   rewind_cmd,
	input  wire logic   offline_cmd,
	input  wire logic   interlock_open,
	output logic        moving_fwd,
	output logic        moving_rev,
	output logic        write_enable_flop,
	output logic        write_current,
	output logic        erase_current,
	output logic [8:0]  char_written,
	output logic        char_valid
);
	logic [1:0]  s_sel, s_fwd, s_rev, s_ovw, s_write_amp_shutoff, s_stb;
	logic [31:0] stop_cnt;
	logic        stb_q;
	logic [8:0]  char_q;
	logic        wr_flop_q;
	logic [3:0]  s_cmd0, s_cmd1;
	wire  run       = s_fwd[1] | s_rev[1];
	wire  clear_sel = |s_cmd1;
	wire  stb_rise  = s_stb[1] & ~stb_q;
	wire  [31:0] stop_cyc = ptw_ms_cycles(STOP_MS, 8'(BASE_IPS));
	wire  cut_off   = s_ovw[1] & s_write_amp_shutoff[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{s_sel, s_fwd, s_rev, s_ovw, s_write_amp_shutoff, s_stb} <= 12'h000;
			s_cmd0 <= 4'h0;
			s_cmd1 <= 4'h0;
			moving_fwd <= 1'b0;
			moving_rev <= 1'b0;
			stop_cnt <= 32'h0;
			wr_flop_q <= 1'b0;
			write_enable_flop <= 1'b0;
			write_current <= 1'b0;
			erase_current <= 1'b0;
			stb_q <= 1'b0;
			char_q <= 9'h000;
			char_written <= 9'h000;
			char_valid <= 1'b0;
			link.motion <= 1'b0;
		end else if (ce) begin
			s_sel <= {s_sel[0], link.write_select_request};
			s_fwd <= {s_fwd[0], link.forward_run_cmd};
			s_rev <= {s_rev[0], link.reverse_run_cmd};
			s_ovw <= {s_ovw[0], link.overwrite_line};
			s_write_amp_shutoff <= {s_write_amp_shutoff[0], link.write_amp_shutoff};
			s_stb <= {s_stb[0], link.write_char_strobe};
			// panel pins are asynchronous: two flops before the clear logic
			s_cmd0 <= {read_cmd, rewind_cmd, offline_cmd, interlock_open};
			s_cmd1 <= s_cmd0;
			stb_q <= s_stb[1];
			if (run) begin
				moving_fwd <= s_fwd[1];
				moving_rev <= s_rev[1] & ~s_fwd[1];
				stop_cnt <= stop_cyc;
			end else if (stop_cnt > 32'h1) begin
				stop_cnt <= stop_cnt - 32'h1;
			end else begin
				moving_fwd <= 1'b0;
				moving_rev <= 1'b0;
				stop_cnt <= 32'h0;
			end
			link.motion <= run | (stop_cnt > 32'h1);
			if (clear_sel)
				wr_flop_q <= 1'b0;
			else if (s_fwd[1] & s_sel[1])
				wr_flop_q <= 1'b1;
			write_enable_flop <= wr_flop_q;
			write_current <= wr_flop_q & s_fwd[1] & ~cut_off;
			erase_current <= wr_flop_q & ~cut_off;
			char_q <= {link.write_parity_line, link.write_char_lines};
			char_valid <= stb_rise & wr_flop_q & ~cut_off;
			if (stb_rise)
				char_written <= char_q;
		end
	end
endmodule

/* verif/ptw_link_assertions.sv */
// assertions on the controller to transport write link
`timescale 1ns/1ps
module ptw_link_assertions
	import ptw_pkg::*;
#(
	parameter int unsigned STOP_MS = 1,
	parameter int unsigned DIV     = 8
) (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       write_select_request,
	input wire logic       forward_run_cmd,
	input wire logic       reverse_run_cmd,
	input wire logic       overwrite_line,
	input wire logic       write_amp_shutoff,
	input wire logic       write_char_strobe,
	input wire logic       write_parity_line,
	input wire logic [7:0] write_char_lines,
	input wire logic       motion
);
	// margin covers the pin sync flops on both ends
	localparam int unsigned STOP_CYC = STOP_MS * CYC_PER_MS + 16;
	logic        prev_strobe;
	logic [31:0] gap;
	logic [31:0] stop_cnt;
	wire         strobe_rise   = write_char_strobe & ~prev_strobe;
	wire         coasting      = motion & ~forward_run_cmd & ~reverse_run_cmd;
	wire  [31:0] next_gap      = strobe_rise ? 32'h1 : (gap < 32'(2 * DIV)) ? gap + 32'h1 : gap;
	wire  [31:0] next_stop_cnt = coasting ? stop_cnt + 32'h1 : 32'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_strobe <= 1'b0;
			gap         <= 32'h0;
			stop_cnt    <= 32'h0;
		end else begin
			prev_strobe <= write_char_strobe;
			gap         <= next_gap;
			stop_cnt    <= next_stop_cnt;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	chk_fwd_after_select: assert property ($rose(forward_run_cmd) |-> $past(write_select_request))
		else $error("forward run raised before write select");
	chk_fwd_from_rest: assert property ($rose(forward_run_cmd) |-> !motion)
		else $error("forward run raised while tape moving");
	chk_motion_starts: assert property ($rose(forward_run_cmd) |-> ##[1:12] motion)
		else $error("tape did not start after forward run");
	chk_motion_has_cause: assert property ($rose(motion) |-> forward_run_cmd || reverse_run_cmd)
		else $error("tape started without a run command");
	chk_stop_time_bound: assert property (stop_cnt <= STOP_CYC)
		else $error("tape still moving past the stop time");
	chk_strobe_in_run: assert property (write_char_strobe |-> forward_run_cmd && write_select_request)
		else $error("character strobe outside a forward write");
	chk_strobe_rate_exact: assert property (strobe_rise && gap > 0 && gap < 2 * DIV |-> gap == DIV)
		else $error("character strobe period wrong");
	chk_chars_held: assert property ($rose(write_char_strobe) |=> $stable({write_parity_line, write_char_lines}))
		else $error("character lines changed right after strobe");
	cover property ($fell(forward_run_cmd));
	cover property (strobe_rise);
	cover property ($fell(motion));
endmodule

/* verif/tb.sv */
// self-checking bench: controller and transport joined over the write link
`timescale 1ns/1ps
module tb;
	import ptw_pkg::*;
	localparam int unsigned STOP = 1;
	localparam int unsigned DIVT = 8;
	localparam int unsigned IPS  = 255;
	logic        hclk           = 1'b0;
	logic        hresetn        = 1'b0;
	logic        ce             = 1'b1;
	logic        read_cmd       = 1'b0;
	logic        rewind_cmd     = 1'b0;
	logic        offline_cmd    = 1'b0;
	logic        interlock_open = 1'b0;
	logic        hsel           = 1'b0;
	logic [31:0] haddr          = 32'h0;
	logic [1:0]  htrans         = 2'h0;
	logic        hwrite         = 1'b0;
	logic [2:0]  hsize          = 3'h2;
	logic [31:0] hwdata         = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        moving_fwd;
	logic        moving_rev;
	logic        write_enable_flop;
	logic        write_current;
	logic        erase_current;
	logic [8:0]  char_written;
	logic        char_valid;
	logic        prev_fwd       = 1'b0;
	logic        prev_stb       = 1'b0;
	int unsigned fails          = 0;
	int unsigned n_checks       = 0;
	int unsigned cyc            = 0;
	int unsigned t_run, t_first, t_last, t_stop;
	logic [8:0]  got_q[$];
	logic [8:0]  exp_q[$];
	logic [7:0]  dat_q[$];
	ptw_link_if ptw_link_if_i ();
	wire fwd = ptw_link_if_i.forward_run_cmd;
	wire stb = ptw_link_if_i.write_char_strobe;
	ptw_controller #(.DIV(DIVT)) ptw_controller_i (.hclk, .hresetn, .ce, .link(ptw_link_if_i), .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
	ptw_transport #(.STOP_MS(STOP)) ptw_transport_i (.hclk, .hresetn, .ce, .link(ptw_link_if_i), .read_cmd,
		.rewind_cmd, .offline_cmd, .interlock_open, .moving_fwd, .moving_rev, .write_enable_flop,
		.write_current, .erase_current, .char_written, .char_valid);
	ptw_link_assertions #(.STOP_MS(STOP), .DIV(DIVT)) ptw_link_assertions_i (.hclk, .hresetn,
		.write_select_request(ptw_link_if_i.write_select_request), .forward_run_cmd(fwd),
		.reverse_run_cmd(ptw_link_if_i.reverse_run_cmd), .overwrite_line(ptw_link_if_i.overwrite_line),
		.write_amp_shutoff(ptw_link_if_i.write_amp_shutoff), .write_char_strobe(stb),
		.write_parity_line(ptw_link_if_i.write_parity_line), .write_char_lines(ptw_link_if_i.write_char_lines),
		.motion(ptw_link_if_i.motion));
	always #20 hclk = ~hclk;
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 16);
		if (k >= 16) fails++;
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk("bus response", 32'h0, {31'h0, hresp});
	endtask
	// delays shrink with speed: count at 25 ips scaled by 25 over the set speed
	function automatic int unsigned exp_cyc(input int unsigned ms);
		return ms * BASE_IPS * CYC_PER_MS / IPS;
	endfunction
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		prev_fwd <= fwd;
		prev_stb <= stb;
		if (fwd && !prev_fwd) t_run = cyc;
		if (!fwd && prev_fwd) t_stop = cyc;
		if (stb && !prev_stb) begin
			if (t_first == 0) chk("write current on", 32'h1, {31'h0, write_current});
			if (t_first == 0) chk("erase current on", 32'h1, {31'h0, erase_current});
			if (t_first == 0) chk("moving forward", 32'h1, {31'h0, moving_fwd});
			if (t_first == 0) chk("not reversing", 32'h0, {31'h0, moving_rev});
			if (t_first == 0) t_first = cyc;
			t_last = cyc;
		end
		if (char_valid === 1'b1) got_q.push_back(char_written);
	end
	// whole run is near 75k cycles, most of it pre delay and stop time
	initial begin
		repeat (95000) @(posedge hclk);
		fails++;
		end_sim();
	end
	initial begin
		logic [31:0] rd;
		logic [31:0] junk;
		int unsigned len, pre, post, idx;
		logic        prev_req;
		logic        ok;
		void'($urandom(21));
		t_first = 0;
		idx = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, OFS_STATUS, 32'h0, rd);
		chk("status idle", 32'h0, rd);
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk("unmapped read", 32'h0, rd);
		len = 3 + $urandom % 4;
		ahb(1'b1, OFS_LENGTH, len, rd);
		ahb(1'b0, OFS_LENGTH, 32'h0, rd);
		chk("length readback", len, rd);
		$display("test registers done");
		dat_q = {8'hff, 8'h00};
		while (dat_q.size() < len) dat_q.push_back(8'($urandom));
		ahb(1'b1, OFS_CTRL, (32'(IPS) << CTRL_SPEED_LSB) | (32'h1 << CTRL_DUAL) | 32'h1, rd);
		prev_req = 1'b0;
		rd = 32'h0;
		for (int i = 0; i < 40000 && rd[STAT_DONE] !== 1'b1; i++) begin
			ahb(1'b0, OFS_STATUS, 32'h0, rd);
			if (rd[STAT_DREQ] === 1'b1 && !prev_req && idx < len) begin
				ahb(1'b1, OFS_DATA, {24'h0, dat_q[idx]}, junk);
				idx++;
			end
			prev_req = rd[STAT_DREQ];
		end
		chk("done flag", 32'h1, {31'h0, rd[STAT_DONE]});
		for (int i = 0; i < 40000 && ptw_link_if_i.motion !== 1'b0; i++) @(posedge hclk);
		chk("tape stopped", 32'h0, {31'h0, moving_fwd});
		repeat (PREAMBLE_ZEROS) exp_q.push_back(9'h000);
		exp_q.push_back(ALL_ONES);
		foreach (dat_q[i]) exp_q.push_back({~(^dat_q[i]), dat_q[i]});
		exp_q.push_back(ALL_ONES);
		repeat (POSTAMBLE_ZEROS) exp_q.push_back(9'h000);
		chk("char count", 32'(exp_q.size()), 32'(got_q.size()));
		foreach (exp_q[i]) if (i < got_q.size()) chk("char", {23'h0, exp_q[i]}, {23'h0, got_q[i]});
		pre = t_first - t_run;
		post = t_stop - t_last;
		ok = pre >= exp_cyc(PRE_NORM_D9_MS) && pre <= exp_cyc(PRE_NORM_D9_MS) + 4 * DIVT + 16;
		chk("pre delay", 32'h1, {31'h0, ok});
		ok = post >= exp_cyc(POST_WRITE_MS) && post <= exp_cyc(POST_WRITE_MS) + 8 * DIVT + 32;
		chk("post delay", 32'h1, {31'h0, ok});
		$display("test write done");
		chk("write flop held", 32'h1, {31'h0, write_enable_flop});
		chk("erase held", 32'h1, {31'h0, erase_current});
		read_cmd <= 1'b1;
		repeat (4) @(posedge hclk);
		read_cmd <= 1'b0;
		repeat (4) @(posedge hclk);
		chk("write flop cleared", 32'h0, {31'h0, write_enable_flop});
		chk("erase stopped", 32'h0, {31'h0, erase_current});
		$display("test flop done");
		end_sim();
	end
endmodule
